// *** logic/csp_map.vh ***
// Register offsets, field positions and reset values of the socket supply/clock block
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
`define CSP_OFF_SUPPLY     12'h010
`define CSP_OFF_CLKPM      12'h020
`define CSP_OFF_IRQ_STAT   12'h030
`define CSP_OFF_IRQ_MASK   12'h034
`define CSP_OFF_CARD_TYPE  12'h038
`define CSP_VPP_LSB        0
`define CSP_VCC_LSB        4
`define CSP_HALT_BIT       7
`define CSP_ONE_BIT        10
`define CSP_THR_SEL_BIT    0
`define CSP_THR_EN_BIT     16
`define CSP_RATE_BIT       24
`define CSP_TOUCH_BIT      25
`define CSP_VCC_OFF        3'h0
`define CSP_VCC_5V         3'h2
`define CSP_VCC_3V3        3'h3
`define CSP_VCC_YV         3'h5
`define CSP_VPP_OFF        3'h0
`define CSP_VPP_12V        3'h1
`define CSP_VPP_5V         3'h2
`define CSP_VPP_3V3        3'h3
`define CSP_VPP_XV         3'h4
`define CSP_VPP_YV         3'h5
`define CSP_SLOW_DIV       5'h10
`define CSP_IRQ_TOUCH      0
`define CSP_IRQ_REFUSE     1
`define CSP_IRQ_RATE       2
`endif

// *** logic/csp_supply_check.v ***
// Decides whether a supply request suits the card type present
`timescale 1ns/1ps
`default_nettype none
`include "csp_map.vh"
module csp_supply_check (
    // Request and card capability
    input  wire [2:0] vcc_req_i,
    input  wire [2:0] vpp_req_i,
    input  wire [3:0] card_volt_i,
    input  wire       card_present_i,
    // Verdict
    output reg        accept_o
);
    reg vcc_ok;
    reg vpp_ok;
    // card_volt_i bits: 0 = 5 V, 1 = 3.3 V, 2 = X.X V, 3 = Y.Y V capable
    always @* begin
        case (vcc_req_i)
            `CSP_VCC_OFF: vcc_ok = 1'b1;
            `CSP_VCC_5V:  vcc_ok = card_present_i & card_volt_i[0];
            `CSP_VCC_3V3: vcc_ok = card_present_i & card_volt_i[1];
            `CSP_VCC_YV:  vcc_ok = card_present_i & card_volt_i[3];
            default:      vcc_ok = 1'b0;
        endcase
        case (vpp_req_i)
            `CSP_VPP_OFF: vpp_ok = 1'b1;
            `CSP_VPP_12V: vpp_ok = card_present_i;
            `CSP_VPP_5V:  vpp_ok = card_present_i & card_volt_i[0];
            `CSP_VPP_3V3: vpp_ok = card_present_i & card_volt_i[1];
            `CSP_VPP_XV:  vpp_ok = card_present_i & card_volt_i[2];
            `CSP_VPP_YV:  vpp_ok = card_present_i & card_volt_i[3];
            default:      vpp_ok = 1'b0;
        endcase
        accept_o = vcc_ok & vpp_ok;
    end
endmodule
`default_nettype wire

// *** logic/csp_clk_throttle.v ***
// Card clock stop / divide-by-16 engine
`timescale 1ns/1ps
`default_nettype none
`include "csp_map.vh"
module csp_clk_throttle (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Policy
    input  wire enable_i,
    input  wire slow_sel_i,
    input  wire halt_any_i,
    input  wire bus_stop_pending_i,
    input  wire card_idle_i,
    // Results
    output reg  card_clk_en_o,
    output reg  throttled_o
);
    reg  [4:0] div_cnt;
    wire       try_now;
    // Throttle only when enabled, card idle and policy allows
    assign try_now = enable_i & card_idle_i & (halt_any_i | bus_stop_pending_i);
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt       <= 5'h00;
            card_clk_en_o <= 1'b1;
            throttled_o   <= 1'b0;
        end else begin
            throttled_o <= try_now;
            if (!try_now) begin
                div_cnt       <= 5'h00;
                card_clk_en_o <= 1'b1;
            end else if (!slow_sel_i) begin
                card_clk_en_o <= 1'b0;        // Stopped
            end else begin
                // One enable every 16 clocks
                div_cnt       <= (div_cnt == `CSP_SLOW_DIV - 5'h01) ? 5'h00 : div_cnt + 5'h01;
                card_clk_en_o <= (div_cnt == 5'h00);
            end
        end
    end
endmodule
`default_nettype wire

// *** logic/csp_socket_ctrl.v ***
// Socket supply request and card clock power management registers over APB
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csp_map.vh"
module csp_socket_ctrl (
    // Clock and resets
    input  wire        SYS_CLK_I,
    input  wire        RST_I,
    input  wire        BUS_RESET_I,
    input  wire        PME_ENABLE_I,
    // APB slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // Card side
    input  wire        CARD_PRESENT_I,
    input  wire [3:0]  CARD_VOLT_I,
    input  wire        CARD_ACCESS_I,
    input  wire        CARD_IDLE_I,
    input  wire        BUS_STOP_PENDING_I,
    output reg  [2:0]  CARD_SUPPLY_O,
    output reg  [2:0]  PROGRAM_VOLTAGE_O,
    output reg         CARD_CLK_EN_O,
    // Interrupt
    output reg         IRQ_O
);
    // Register state
    reg  [2:0] card_supply_request;
    reg  [2:0] program_voltage_request;
    reg        clock_halt_policy;
    reg        clock_throttle_enable;
    reg        clock_throttle_select;
    reg        socket_touched_flag;
    reg        clock_rate_changed_flag;
    reg  [2:0] irq_stat;
    reg  [2:0] irq_mask;
    reg  [2:0] next_card_supply;
    reg  [2:0] next_program_voltage;
    reg  [31:0] next_rdata;
    reg        next_err;
    // Internal signals
    wire       access_phase;
    wire       wr_now;
    wire       rd_now;
    wire       ctx_clear;
    wire       supply_ok;
    wire       clk_en_int;
    wire       throttled;
    wire       rate_rise;
    wire       touch_rise;
    wire       refuse_evt;
    wire [2:0] irq_events;
    reg        prev_throttled;
    // Slave answers in the access phase itself: zero wait states
    assign access_phase = PSEL_I & PENABLE_I;
    assign wr_now       = access_phase & PWRITE_I;
    assign rd_now       = access_phase & ~PWRITE_I;
    assign ctx_clear = RST_I | (BUS_RESET_I & ~PME_ENABLE_I);

    csp_supply_check u_check (
        .vcc_req_i      (PWDATA_I[`CSP_VCC_LSB+2:`CSP_VCC_LSB]),
        .vpp_req_i      (PWDATA_I[`CSP_VPP_LSB+2:`CSP_VPP_LSB]),
        .card_volt_i    (CARD_VOLT_I),
        .card_present_i (CARD_PRESENT_I),
        .accept_o       (supply_ok)
    );

    csp_clk_throttle u_throttle (
        .clk_i              (SYS_CLK_I),
        .rst_i              (RST_I),
        .enable_i           (clock_throttle_enable),
        .slow_sel_i         (clock_throttle_select),
        .halt_any_i         (clock_halt_policy),
        .bus_stop_pending_i (BUS_STOP_PENDING_I),
        .card_idle_i        (CARD_IDLE_I),
        .card_clk_en_o      (clk_en_int),
        .throttled_o        (throttled)
    );

    // Refused supply writes leave the request unchanged and raise an event
    assign refuse_evt = wr_now & (PADDR_I == `CSP_OFF_SUPPLY) & ~supply_ok;

    always @* begin
        next_card_supply     = card_supply_request;
        next_program_voltage = program_voltage_request;
        if (wr_now && PADDR_I == `CSP_OFF_SUPPLY && supply_ok) begin
            next_card_supply     = PWDATA_I[`CSP_VCC_LSB+2:`CSP_VCC_LSB];
            next_program_voltage = PWDATA_I[`CSP_VPP_LSB+2:`CSP_VPP_LSB];
        end
    end

    // context registers, kept across bus reset when PME enabled
    always @(posedge SYS_CLK_I) begin
        if (ctx_clear) begin
            card_supply_request     <= `CSP_VCC_OFF;
            program_voltage_request <= `CSP_VPP_OFF;
            clock_halt_policy       <= 1'b0;
        end else begin
            card_supply_request     <= next_card_supply;
            program_voltage_request <= next_program_voltage;
            if (wr_now && PADDR_I == `CSP_OFF_SUPPLY)
                clock_halt_policy <= PWDATA_I[`CSP_HALT_BIT];
        end
    end

    // Throttle controls are cleared by either reset
    always @(posedge SYS_CLK_I) begin
        if (RST_I | BUS_RESET_I) begin
            clock_throttle_enable <= 1'b0;
            clock_throttle_select <= 1'b0;
        end else if (wr_now && PADDR_I == `CSP_OFF_CLKPM) begin
            clock_throttle_enable <= PWDATA_I[`CSP_THR_EN_BIT];
            clock_throttle_select <= PWDATA_I[`CSP_THR_SEL_BIT];
        end
    end

    // status bits see only the global reset
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            socket_touched_flag     <= 1'b0;
            clock_rate_changed_flag <= 1'b0;
            prev_throttled          <= 1'b0;
        end else begin
            prev_throttled          <= throttled;
            clock_rate_changed_flag <= throttled;
            // access flag, a fresh access wins over the read clear
            if (CARD_ACCESS_I)
                socket_touched_flag <= 1'b1;
            else if (rd_now && PADDR_I == `CSP_OFF_CLKPM)
                socket_touched_flag <= 1'b0;
        end
    end

    assign touch_rise = CARD_ACCESS_I & ~socket_touched_flag;
    assign rate_rise  = throttled & ~prev_throttled;
    assign irq_events = {rate_rise, refuse_evt, touch_rise};

    // Sticky interrupt status, write one to clear, set beats clear
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
            always @(posedge SYS_CLK_I) begin
                if (RST_I)
                    irq_stat[gi] <= 1'b0;
                else if (irq_events[gi])
                    irq_stat[gi] <= 1'b1;
                else if (wr_now && PADDR_I == `CSP_OFF_IRQ_STAT && PWDATA_I[gi])
                    irq_stat[gi] <= 1'b0;
            end
        end
    endgenerate

    // Interrupt mask
    always @(posedge SYS_CLK_I) begin
        if (RST_I)
            irq_mask <= 3'h0;
        else if (wr_now && PADDR_I == `CSP_OFF_IRQ_MASK)
            irq_mask <= PWDATA_I[2:0];
    end

    // Read mux; unmapped addresses read zero with an error
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (PADDR_I)
            `CSP_OFF_SUPPLY: begin
                // fixed one at bit 10, other spare bits zero
                next_rdata[`CSP_ONE_BIT]                  = 1'b1;
                next_rdata[`CSP_HALT_BIT]                 = clock_halt_policy;
                next_rdata[`CSP_VCC_LSB+2:`CSP_VCC_LSB]   = card_supply_request;
                next_rdata[`CSP_VPP_LSB+2:`CSP_VPP_LSB]   = program_voltage_request;
            end
            `CSP_OFF_CLKPM: begin
                next_rdata[`CSP_TOUCH_BIT]   = socket_touched_flag;
                next_rdata[`CSP_RATE_BIT]    = clock_rate_changed_flag;
                next_rdata[`CSP_THR_EN_BIT]  = clock_throttle_enable;
                next_rdata[`CSP_THR_SEL_BIT] = clock_throttle_select;
            end
            `CSP_OFF_IRQ_STAT:  next_rdata[2:0] = irq_stat;
            `CSP_OFF_IRQ_MASK:  next_rdata[2:0] = irq_mask;
            `CSP_OFF_CARD_TYPE: next_rdata[4:0] = {CARD_PRESENT_I, CARD_VOLT_I};
            default:            next_err = 1'b1;
        endcase
    end

    // Registered APB answer: ready in the first cycle of the access phase
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PRDATA_O  <= next_rdata;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & next_err;
        end
    end

    // Registered outputs toward the card and host
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            CARD_SUPPLY_O     <= `CSP_VCC_OFF;
            PROGRAM_VOLTAGE_O <= `CSP_VPP_OFF;
            CARD_CLK_EN_O     <= 1'b1;
            IRQ_O             <= 1'b0;
        end else begin
            CARD_SUPPLY_O     <= CARD_PRESENT_I ? card_supply_request : `CSP_VCC_OFF;
            PROGRAM_VOLTAGE_O <= CARD_PRESENT_I ? program_voltage_request : `CSP_VPP_OFF;
            // divided or stopped card clock enable
            CARD_CLK_EN_O     <= clk_en_int;
            IRQ_O             <= |(irq_stat & irq_mask);
        end
    end
endmodule
`default_nettype wire

// *** test/csp_ctrl_asserts.sv ***
// Port-level assertions for the socket supply and clock control block
`timescale 1ns/1ps
`default_nettype none
module csp_ctrl_asserts (
    // Clock and resets
    input wire logic        SYS_CLK_I,
    input wire logic        RST_I,
    input wire logic        BUS_RESET_I,
    input wire logic        PME_ENABLE_I,
    // APB
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    // Card side
    input wire logic        CARD_PRESENT_I,
    input wire logic        CARD_IDLE_I,
    input wire logic        BUS_STOP_PENDING_I,
    input wire logic [2:0]  CARD_SUPPLY_O,
    input wire logic        CARD_CLK_EN_O
);
    logic       en;
    logic       slow;
    logic       halt;
    logic [4:0] gap;
    logic [6:0] run;
    wire        wr  = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    wire        rd  = PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O;
    wire        stp = en && CARD_IDLE_I && (halt || BUS_STOP_PENDING_I);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    // Shadow of throttle and policy bits; policy survives bus reset while PME is on
    always @(posedge SYS_CLK_I) begin
        if (RST_I || BUS_RESET_I) begin
            en   <= 1'b0;
            slow <= 1'b0;
        end else if (wr && PADDR_I == 12'h020) begin
            en   <= PWDATA_I[16];
            slow <= PWDATA_I[0];
        end
        if (RST_I || (BUS_RESET_I && !PME_ENABLE_I))
            halt <= 1'b0;
        else if (wr && PADDR_I == 12'h010)
            halt <= PWDATA_I[7];
    end

    // Low cycles between clock pulses, and how long slowing has been requested
    always @(posedge SYS_CLK_I) begin
        gap <= CARD_CLK_EN_O ? 5'h00 : (gap == 5'h1F ? gap : gap + 5'h01);
        run <= (stp && slow) ? (run == 7'h7F ? run : run + 7'h01) : 7'h00;
    end

    AST_NO_CARD_OFF: assert property ((!CARD_PRESENT_I) [*3] |-> CARD_SUPPLY_O == 3'h0)
        else $error("supply applied with no card");
    AST_SUPPLY_FIXED: assert property (rd && PADDR_I == 12'h010 |-> (PRDATA_O & 32'hFFFFFF08) == 32'h00000400)
        else $error("supply register fixed bits wrong");
    AST_PM_FIXED: assert property (rd && PADDR_I == 12'h020 |-> (PRDATA_O & 32'hFCFEFFFE) == 32'h00000000)
        else $error("clock register unused bits set");
    AST_OFF_RUNS: assert property ((!en) [*4] |-> CARD_CLK_EN_O)
        else $error("clock throttled while disabled");
    AST_STOP: assert property ((stp && !slow) [*5] |-> !CARD_CLK_EN_O)
        else $error("idle card clock not stopped");
    AST_SLOW_DIV: assert property (run > 7'd40 && CARD_CLK_EN_O |-> gap == 5'd15)
        else $error("slowed clock not one in sixteen");
    AST_POLICY_WAIT: assert property ((en && !halt && !BUS_STOP_PENDING_I) [*4] |-> CARD_CLK_EN_O)
        else $error("throttled without bus stop preparation");
    AST_BUS_RST_CLR: assert property (BUS_RESET_I && !PME_ENABLE_I |-> ##3 CARD_SUPPLY_O == 3'h0)
        else $error("bus reset left supply on");

    // Main scenarios reached
    C_SLOWED: cover property ((stp && slow) [*8]);
    C_PME_KEEP: cover property (BUS_RESET_I && PME_ENABLE_I);
    C_STOPPED: cover property ((!CARD_CLK_EN_O) [*8]);
endmodule
bind csp_socket_ctrl csp_ctrl_asserts chk (.*);
`default_nettype wire

// *** test/csp_card_model.sv ***
// Behavioural card in the socket: presence, voltage sense, access and idle
`timescale 1ns/1ps
`default_nettype none
module csp_card_model (
    // Commands from the bench
    input  wire logic       clk_i,
    input  wire logic       insert_i,
    input  wire logic [3:0] cap_i,
    input  wire logic       touch_i,
    // Socket lines
    output logic            present_o,
    output logic [3:0]      volt_o,
    output logic            access_o,
    output logic            idle_o
);
    // Sense lines read as no capability once the card is out
    always @(posedge clk_i) begin
        present_o <= insert_i;
        volt_o    <= insert_i ? cap_i : 4'h0;
        access_o  <= touch_i;
        idle_o    <= !touch_i;
    end
endmodule
`default_nettype wire

// *** test/test_csp_socket_ctrl.sv ***
// Self-checking bench for the socket supply and clock control block
`timescale 1ns/1ps
`default_nettype none
module test_csp_socket_ctrl;
    logic        clk = 0, rst = 1, brst = 0, pme = 0, psel = 0, pen = 0, pwr = 0;
    logic        insert = 1, touch = 0, bstop = 0, err;
    logic        pready, pslverr, clken, irq, present, access, idle;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0]  cap = 4'hF, volt;
    logic [2:0]  supply, vpp, cv = 3'h0, cp = 3'h0, v, p;
    int          err_count = 0, compares = 0, i, n;

    always #2 clk = ~clk;

    csp_socket_ctrl uut (.SYS_CLK_I(clk), .RST_I(rst), .BUS_RESET_I(brst), .PME_ENABLE_I(pme),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CARD_PRESENT_I(present),
        .CARD_VOLT_I(volt), .CARD_ACCESS_I(access), .CARD_IDLE_I(idle),
        .BUS_STOP_PENDING_I(bstop), .CARD_SUPPLY_O(supply), .PROGRAM_VOLTAGE_O(vpp),
        .CARD_CLK_EN_O(clken), .IRQ_O(irq));
    csp_card_model card (.clk_i(clk), .insert_i(insert), .cap_i(cap), .touch_i(touch),
        .present_o(present), .volt_o(volt), .access_o(access), .idle_o(idle));

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (exp !== got) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1;
        pen    <= 0;
        paddr  <= a;
        pwr    <= w;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        // A slave that never answers ends the run as a mismatch
        if (pready !== 1'b1) begin
            err_count++;
            test_done;
        end else begin
            rdata = prdata;
            err   = pslverr;
            psel <= 0;
            pen  <= 0;
        end
    endtask

    task automatic bus_reset;
        brst <= 1;
        @(posedge clk);
        brst <= 0;
    endtask

    // Whether a code is honoured for this card; vp marks the programming field
    function automatic logic ok_code(input logic [2:0] c, input logic vp, input logic [3:0] k);
        case (c)
            3'h0: return 1'b1;
            3'h1: return vp;
            3'h2: return k[0];
            3'h3: return k[1];
            3'h4: return vp & k[2];
            3'h5: return k[3];
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        n = $urandom(63591);
        repeat (3) @(posedge clk);
        rst <= 0;
        apb(12'h010, 0, 0); check("supply reset", 32'h400, rdata);
        apb(12'h020, 0, 0); check("clock reg reset", 0, rdata);
        apb(12'h0FC, 0, 0); check("unmapped error", 1, err);
        // Every code pair, random card and random junk in unused bits
        for (i = 0; i < 64; i++) begin
            cap <= 4'($urandom);
            v = i[2:0];
            p = i[5:3];
            apb(12'h010, 1, ($urandom & 32'hFFFFFF08) | {25'h0, v, 1'b0, p});
            if (ok_code(v, 0, cap) && ok_code(p, 1, cap)) begin
                cv = v;
                cp = p;
            end
            apb(12'h010, 0, 0); check("supply reg", {25'h0, cv, 1'b0, cp} | 32'h400, rdata);
            check("vcc out", cv, supply);
            check("vpp out", cp, vpp);
        end
        // A refused request raises the unmasked interrupt; write-one clears it
        apb(12'h034, 1, 32'h2);
        apb(12'h030, 1, 32'h7);
        apb(12'h010, 1, 32'h10);
        repeat (2) @(posedge clk);
        check("irq raised", 1, irq);
        apb(12'h030, 1, 32'h2);
        repeat (2) @(posedge clk);
        check("irq cleared", 0, irq);
        insert <= 0;
        repeat (4) @(posedge clk);
        check("no card supply", 0, supply);
        insert <= 1;
        cap <= 4'hF;
        // Access flag survives bus reset and clears on read
        touch <= 1;
        @(posedge clk);
        touch <= 0;
        bus_reset;
        apb(12'h020, 0, 0); check("touched", 32'h02000000, rdata);
        apb(12'h020, 0, 0); check("touched read clr", 0, rdata);
        apb(12'h010, 0, 0); check("ctx bus reset", 32'h400, rdata);
        apb(12'h038, 0, 0); check("card type", 32'h1F, rdata);
        // Context bits kept over bus reset only while PME is on
        apb(12'h010, 1, 32'hB1);
        pme <= 1;
        bus_reset;
        apb(12'h010, 0, 0); check("ctx kept", 32'h4B1, rdata);
        pme <= 0;
        bus_reset;
        apb(12'h010, 0, 0); check("ctx cleared", 32'h400, rdata);
        // Stop waits for bus stop preparation under the default policy
        apb(12'h020, 1, 32'h10000);
        repeat (6) @(posedge clk);
        check("clk runs", 1, clken);
        bstop <= 1;
        repeat (6) @(posedge clk);
        check("clk stopped", 0, clken);
        apb(12'h020, 0, 0); check("rate flag", 32'h01010000, rdata);
        apb(12'h030, 0, 0); check("irq status", 32'h5, rdata);
        apb(12'h020, 1, 32'h10001);
        repeat (20) @(posedge clk);
        n = 0;
        repeat (64) begin
            @(posedge clk);
            n += clken;
        end
        check("slow pulses", 4, n);
        bstop <= 0;
        apb(12'h010, 1, 32'h80);
        repeat (8) @(posedge clk);
        apb(12'h020, 0, 0); check("policy any", 32'h01010001, rdata);
        apb(12'h020, 1, 0);
        repeat (6) @(posedge clk);
        check("clk back", 1, clken);
        apb(12'h020, 0, 0); check("rate normal", 0, rdata);
        // Global reset clears everything, PME or not
        touch <= 1;
        pme <= 1;
        @(posedge clk);
        touch <= 0;
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        apb(12'h020, 0, 0); check("global_reset status", 0, rdata);
        apb(12'h010, 0, 0); check("global_reset ctx", 32'h400, rdata);
        test_done;
    end
endmodule
`default_nettype wire
